// [hdl/smcc_mode_clock_config.sv]
// Purpose: Forward-channel mode and reference-clock configuration registers.
// Assumes: Control-channel lock and format inputs run on clock_in; pins are asynchronous.
// Notes: While the power-down pin is low the registers hold their reset values, but the strapped mode and address keep their last captured values.
// How it works
// - The active mode is the strapped mode unless the override bit 4 is set.
// - Bit 3 of the mode register reads one once the captured mode has settled.
// - The mode field always reads the active mode and ignores writes while override is clear.
// - With override set, writes to the mode field become the operating mode.
// - The strapped mode is captured at every rising edge of the power-down pin.
// - Codes 000, 010 and 011 select sync, external-clock and oscillator modes; 001 is reserved.
// - Code 101 selects the legacy parallel video mode on an external clock.
// - The RAW10 bit is loaded from the control channel at receiver lock unless blocked.
// - The RAW12 bit is loaded from the control channel at receiver lock unless blocked.
// - A set auto-load block bit keeps software values of the RAW10 and RAW12 bits.
// - The divider field divides the reference by 1, 2, 4 or 8 for codes 000 to 011.
// - The oscillator is the reference in oscillator mode or without a detected system clock.
// - A clear range bit runs the oscillator at 24.2 to 25.5 MHz for 2 Gbps.
// - A set range bit runs the oscillator at 48.4 to 51 MHz for 4 Gbps.
// - Registers are reached over the I2C target port at a strapped or overridden address.
module smcc_mode_clock_config
   import smcc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // Strap and status pins
   input wire logic powerdown_n_pin_in,
   input wire logic [2:0] strap_mode_in,
   input wire logic [6:0] strap_id_in,
   input wire logic ext_clock_detect_in,
   // Control channel
   input wire logic rx_lock_in,
   input wire logic [1:0] legacy_format_in,
   // I2C target pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Configuration outputs
   output logic [2:0] active_mode_out,
   output logic mode_done_out,
   output logic raw10_legacy_select_out,
   output logic raw12_legacy_select_out,
   output logic [2:0] refin_divider_out,
   output logic internal_osc_range_select_out,
   output logic use_internal_osc_out
);
   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic pdb_meta, pdb_sync, pdb_last, clk_meta, clk_sync;
   logic [2:0] mode_meta, mode_sync;
   logic [6:0] id_meta, id_sync;

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         {pdb_meta, pdb_sync, pdb_last} <= 3'h0;
         {clk_meta, clk_sync} <= 2'h0;
         {mode_meta, mode_sync} <= 6'h00;
         {id_meta, id_sync} <= 14'h0000;
      end
      else
      begin
         {pdb_meta, pdb_sync, pdb_last} <= {powerdown_n_pin_in, pdb_meta, pdb_sync};
         {clk_meta, clk_sync} <= {ext_clock_detect_in, clk_meta};
         {mode_meta, mode_sync} <= {strap_mode_in, mode_meta};
         {id_meta, id_sync} <= {strap_id_in, id_meta};
      end
   end

   // ***************************************************************
   // I2C target
   // ***************************************************************
   logic [7:0] pointer, read_data;
   logic [6:0] active_id;
   smcc_write_type write;

   smcc_i2c_target u_i2c_target (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .target_id_in(active_id),
      .read_data_in(read_data),
      .pointer_out(pointer),
      .write_out(write)
   );

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic id_override, next_id_override, mode_override, next_mode_override;
   logic [6:0] id_written, next_id_written, strap_id, next_strap_id;
   logic [2:0] mode_written, next_mode_written, strap_mode, next_strap_mode, active_mode;
   logic mode_done, next_mode_done, fwd_spare7, next_fwd_spare7, fwd_spare5, next_fwd_spare5;
   logic [4:0] settle_count, next_settle_count, legacy_spare, next_legacy_spare;
   logic raw10, next_raw10, raw12, next_raw12, autoload_block, next_autoload_block;
   logic pll_spare7, next_pll_spare7, osc_range, next_osc_range, lock_last;
   logic [2:0] refin_div, next_refin_div, pll_spare, next_pll_spare;

   always_comb
   begin
      active_id = id_override ? id_written : strap_id;
      active_mode = mode_override ? mode_written : strap_mode;
      unique case (pointer)
         ADDR_DEVICE_ID: read_data = {active_id, id_override};
         ADDR_FORWARD_MODE: read_data = {fwd_spare7, 1'b0, fwd_spare5, mode_override,
                                         mode_done, active_mode};
         ADDR_LEGACY_FORMAT: read_data = {legacy_spare, raw10, raw12, autoload_block};
         ADDR_PLL_REFERENCE: read_data = {pll_spare7, refin_div, osc_range, pll_spare};
         default: read_data = 8'h00;
      endcase
   end

   always_comb
   begin
      next_id_override = id_override;
      next_id_written = id_written;
      next_strap_id = strap_id;
      next_mode_override = mode_override;
      next_mode_written = mode_written;
      next_strap_mode = strap_mode;
      next_mode_done = mode_done;
      next_settle_count = settle_count;
      next_fwd_spare7 = fwd_spare7;
      next_fwd_spare5 = fwd_spare5;
      next_legacy_spare = legacy_spare;
      next_raw10 = raw10;
      next_raw12 = raw12;
      next_autoload_block = autoload_block;
      next_pll_spare7 = pll_spare7;
      next_refin_div = refin_div;
      next_osc_range = osc_range;
      next_pll_spare = pll_spare;
      if (!pdb_sync)
      begin
         next_id_override = DEVICE_ID_RESET[ID_OVERRIDE_BIT];
         next_mode_override = FORWARD_MODE_RESET[STRAP_OVERRIDE_BIT];
         next_mode_done = 1'b0;
         next_settle_count = 5'h00;
         {next_fwd_spare7, next_fwd_spare5} = {FORWARD_MODE_RESET[7], FORWARD_MODE_RESET[5]};
         {next_legacy_spare, next_raw10, next_raw12, next_autoload_block} = LEGACY_FORMAT_RESET;
         {next_pll_spare7, next_refin_div, next_osc_range, next_pll_spare} = PLL_REFERENCE_RESET;
      end
      else
      begin
         if (!pdb_last)
         begin
            // Straps are sampled once per power-up so later pin noise cannot move the mode.
            next_strap_mode = mode_sync;
            next_strap_id = id_sync;
            next_settle_count = 5'h00;
            next_mode_done = 1'b0;
         end
         else if (!mode_done)
         begin
            next_settle_count = settle_count + 5'h01;
            next_mode_done = (settle_count == MODE_SETTLE_LAST);
         end
         if (write.strobe)
         begin
            unique case (write.addr)
               ADDR_DEVICE_ID:
               begin
                  next_id_override = write.data[ID_OVERRIDE_BIT];
                  if (write.data[ID_OVERRIDE_BIT])
                     next_id_written = write.data[7:1];
               end
               ADDR_FORWARD_MODE:
               begin
                  next_fwd_spare7 = write.data[7];
                  next_fwd_spare5 = write.data[5];
                  next_mode_override = write.data[STRAP_OVERRIDE_BIT];
                  if (write.data[STRAP_OVERRIDE_BIT])
                     next_mode_written = write.data[2:0];
               end
               ADDR_LEGACY_FORMAT:
               begin
                  next_legacy_spare = write.data[7:3];
                  next_raw10 = write.data[RAW10_BIT];
                  next_raw12 = write.data[RAW12_BIT];
                  next_autoload_block = write.data[AUTOLOAD_BLOCK_BIT];
               end
               ADDR_PLL_REFERENCE:
               begin
                  next_pll_spare7 = write.data[7];
                  next_refin_div = write.data[REFIN_DIV_LSB +: 3];
                  next_osc_range = write.data[OSC_RANGE_BIT];
                  next_pll_spare = write.data[2:0];
               end
               default:
               begin
               end
            endcase
         end
         // The control-channel load wins over a same-cycle software write.
         if (rx_lock_in && !lock_last && !autoload_block)
         begin
            next_raw10 = legacy_format_in[1];
            next_raw12 = legacy_format_in[0];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         id_override <= DEVICE_ID_RESET[ID_OVERRIDE_BIT];
         id_written <= DEVICE_ID_RESET[7:1];
         strap_id <= STRAP_ID_RESET;
         mode_override <= FORWARD_MODE_RESET[STRAP_OVERRIDE_BIT];
         mode_written <= FORWARD_MODE_RESET[2:0];
         strap_mode <= STRAP_MODE_RESET;
         mode_done <= 1'b0;
         settle_count <= 5'h00;
         {fwd_spare7, fwd_spare5} <= {FORWARD_MODE_RESET[7], FORWARD_MODE_RESET[5]};
         {legacy_spare, raw10, raw12, autoload_block} <= LEGACY_FORMAT_RESET;
         {pll_spare7, refin_div, osc_range, pll_spare} <= PLL_REFERENCE_RESET;
         lock_last <= 1'b0;
      end
      else
      begin
         id_override <= next_id_override;
         id_written <= next_id_written;
         strap_id <= next_strap_id;
         mode_override <= next_mode_override;
         mode_written <= next_mode_written;
         strap_mode <= next_strap_mode;
         mode_done <= next_mode_done;
         settle_count <= next_settle_count;
         {fwd_spare7, fwd_spare5} <= {next_fwd_spare7, next_fwd_spare5};
         {legacy_spare, raw10, raw12, autoload_block} <=
            {next_legacy_spare, next_raw10, next_raw12, next_autoload_block};
         {pll_spare7, refin_div, osc_range, pll_spare} <=
            {next_pll_spare7, next_refin_div, next_osc_range, next_pll_spare};
         lock_last <= rx_lock_in;
      end
   end

   // ***************************************************************
   // Output flops
   // ***************************************************************
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         active_mode_out <= STRAP_MODE_RESET;
         mode_done_out <= 1'b0;
         raw10_legacy_select_out <= 1'b0;
         raw12_legacy_select_out <= 1'b0;
         refin_divider_out <= PLL_REFERENCE_RESET[REFIN_DIV_LSB +: 3];
         internal_osc_range_select_out <= 1'b0;
         use_internal_osc_out <= 1'b0;
      end
      else
      begin
         active_mode_out <= active_mode;
         mode_done_out <= mode_done;
         raw10_legacy_select_out <= raw10;
         raw12_legacy_select_out <= raw12;
         refin_divider_out <= refin_div;
         internal_osc_range_select_out <= osc_range;
         use_internal_osc_out <= smcc_uses_internal_osc(active_mode, clk_sync);
      end
   end
endmodule // smcc_mode_clock_config

// [shared/smcc_pkg.sv]
// Purpose: Shared constants and types of the serializer mode and clock configuration block.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes: Register offsets are the byte addresses seen by the I2C target port.
package smcc_pkg;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLOCK_FREQ_MHZ = 20;
   localparam int MODE_SETTLE_TIME_NS = 1000;
   localparam int MODE_SETTLE_CYCLES = (MODE_SETTLE_TIME_NS * CLOCK_FREQ_MHZ + 999) / 1000;
   localparam logic [4:0] MODE_SETTLE_LAST = 5'(MODE_SETTLE_CYCLES - 1);

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] ADDR_DEVICE_ID = 8'h00;
   localparam logic [7:0] ADDR_FORWARD_MODE = 8'h03;
   localparam logic [7:0] ADDR_LEGACY_FORMAT = 8'h04;
   localparam logic [7:0] ADDR_PLL_REFERENCE = 8'h05;
   localparam int ID_OVERRIDE_BIT = 0;
   localparam int STRAP_OVERRIDE_BIT = 4;
   localparam int MODE_DONE_BIT = 3;
   localparam int RAW10_BIT = 2;
   localparam int RAW12_BIT = 1;
   localparam int AUTOLOAD_BLOCK_BIT = 0;
   localparam int OSC_RANGE_BIT = 3;
   localparam int REFIN_DIV_LSB = 4;
   localparam logic [7:0] DEVICE_ID_RESET = 8'h00;
   localparam logic [7:0] FORWARD_MODE_RESET = 8'h00;
   localparam logic [7:0] LEGACY_FORMAT_RESET = 8'h00;
   localparam logic [7:0] PLL_REFERENCE_RESET = 8'h03;
   localparam logic [2:0] STRAP_MODE_RESET = 3'h0;
   localparam logic [6:0] STRAP_ID_RESET = 7'h00;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      MODE_SYNC = 3'b000,
      MODE_RESERVED = 3'b001,
      MODE_NONSYNC_EXT = 3'b010,
      MODE_NONSYNC_INT = 3'b011,
      MODE_LEGACY_VIDEO = 3'b101
   } smcc_mode_type;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_ACK = 3'b010,
      I2C_WRITE = 3'b011,
      I2C_READ = 3'b100,
      I2C_RACK = 3'b101,
      I2C_RLOAD = 3'b110
   } smcc_i2c_state_type;

   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } smcc_write_type;

   // The oscillator is the reference in internal-clock mode or when no system clock is seen.
   function automatic logic smcc_uses_internal_osc(input logic [2:0] mode, input logic ext_clk);
      return (mode == MODE_NONSYNC_INT) || !ext_clk;
   endfunction
endpackage

// [hdl/smcc_i2c_target.sv]
// Purpose: I2C target port with an auto-incrementing register pointer.
// Assumes: SCL and SDA are slow against the 50 ns clock; no clock stretching.
// Notes: First data byte of a write sets the pointer, later bytes write registers.
module smcc_i2c_target
   import smcc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Register side
   input wire logic [6:0] target_id_in,
   input wire logic [7:0] read_data_in,
   output logic [7:0] pointer_out,
   output smcc_write_type write_out
);
   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic scl_meta, scl_sync, scl_last, sda_meta, sda_sync, sda_last;

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         {scl_meta, scl_sync, scl_last} <= 3'h7;
         {sda_meta, sda_sync, sda_last} <= 3'h7;
      end
      else
      begin
         {scl_meta, scl_sync, scl_last} <= {scl_in, scl_meta, scl_sync};
         {sda_meta, sda_sync, sda_last} <= {sda_in, sda_meta, sda_sync};
      end
   end

   // ***************************************************************
   // Protocol engine
   // ***************************************************************
   smcc_i2c_state_type state, next_state;
   logic [2:0] bit_count, next_bit_count;
   logic [7:0] shift, next_shift, pointer, next_pointer, rx_byte;
   logic read_dir, next_read_dir, have_pointer, next_have_pointer, drive, next_drive;
   logic scl_rise, scl_fall, start_seen, stop_seen;
   smcc_write_type write, next_write;

   always_comb
   begin
      rx_byte = {shift[6:0], sda_sync};
      scl_rise = scl_sync & ~scl_last;
      scl_fall = ~scl_sync & scl_last;
      start_seen = scl_sync & scl_last & sda_last & ~sda_sync;
      stop_seen = scl_sync & scl_last & ~sda_last & sda_sync;
      next_state = state;
      next_bit_count = bit_count;
      next_shift = shift;
      next_pointer = pointer;
      next_read_dir = read_dir;
      next_have_pointer = have_pointer;
      next_drive = drive;
      next_write = write;
      next_write.strobe = 1'b0;
      if (start_seen)
      begin
         next_state = I2C_ADDR;
         next_bit_count = 3'h0;
         next_drive = 1'b0;
         next_have_pointer = 1'b0;
      end
      else if (stop_seen)
      begin
         next_state = I2C_IDLE;
         next_drive = 1'b0;
      end
      else
      begin
         unique case (state)
            I2C_IDLE:
            begin
            end
            I2C_ADDR, I2C_WRITE:
            begin
               if (scl_rise)
               begin
                  next_shift = rx_byte;
                  next_bit_count = bit_count + 3'h1;
                  if (bit_count == 3'h7)
                  begin
                     next_state = I2C_ACK;
                     if (state == I2C_ADDR)
                     begin
                        next_read_dir = rx_byte[0];
                        if (rx_byte[7:1] != target_id_in)
                           next_state = I2C_IDLE;
                     end
                     else if (!have_pointer)
                     begin
                        next_pointer = rx_byte;
                        next_have_pointer = 1'b1;
                     end
                     else
                     begin
                        next_write = '{strobe: 1'b1, addr: pointer, data: rx_byte};
                        next_pointer = pointer + 8'h01;
                     end
                  end
               end
            end
            I2C_ACK:
            begin
               if (scl_fall)
               begin
                  next_drive = ~drive;
                  if (drive)
                  begin
                     next_bit_count = 3'h0;
                     next_state = read_dir ? I2C_RLOAD : I2C_WRITE;
                  end
               end
            end
            I2C_READ:
            begin
               if (scl_fall)
               begin
                  if (bit_count == 3'h7)
                  begin
                     next_drive = 1'b0;
                     next_state = I2C_RACK;
                  end
                  else
                  begin
                     next_shift = {shift[6:0], 1'b0};
                     next_drive = ~shift[6];
                     next_bit_count = bit_count + 3'h1;
                  end
               end
            end
            I2C_RACK:
            begin
               if (scl_rise)
                  next_state = sda_sync ? I2C_IDLE : I2C_RLOAD;
            end
            I2C_RLOAD:
            begin
               // Loading only while SCL is low keeps SDA stable across the high phase.
               if (!scl_sync)
               begin
                  next_shift = read_data_in;
                  next_drive = ~read_data_in[7];
                  next_pointer = pointer + 8'h01;
                  next_bit_count = 3'h0;
                  next_state = I2C_READ;
               end
            end
            default:
               next_state = I2C_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         state <= I2C_IDLE;
         bit_count <= 3'h0;
         shift <= 8'h00;
         pointer <= 8'h00;
         read_dir <= 1'b0;
         have_pointer <= 1'b0;
         drive <= 1'b0;
         write <= '0;
         sda_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bit_count <= next_bit_count;
         shift <= next_shift;
         pointer <= next_pointer;
         read_dir <= next_read_dir;
         have_pointer <= next_have_pointer;
         drive <= next_drive;
         write <= next_write;
         sda_out <= 1'b0;
      end
   end

   assign sda_oe_out = drive;
   assign pointer_out = pointer;
   assign write_out = write;
endmodule // smcc_i2c_target

// [verif/smcc_checker.sv]
// Purpose: Port assertions for the mode and clock configuration block.
// Assumes: SCL phases last eight clock cycles or more.
// Notes: Bound to every instance of the top module.
module smcc_checker
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // Pins
   input wire logic powerdown_n_pin_in,
   input wire logic ext_clock_detect_in,
   input wire logic rx_lock_in,
   input wire logic scl_in,
   input wire logic sda_in,
   // Outputs watched
   input wire logic sda_oe_out,
   input wire logic [2:0] active_mode_out,
   input wire logic mode_done_out,
   input wire logic raw10_legacy_select_out,
   input wire logic raw12_legacy_select_out,
   input wire logic [2:0] refin_divider_out,
   input wire logic internal_osc_range_select_out,
   input wire logic use_internal_osc_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);
   wire logic [8:0] cfg = {active_mode_out, raw10_legacy_select_out, raw12_legacy_select_out,
      refin_divider_out, internal_osc_range_select_out};
   property p_osc_mode;
      (active_mode_out == 3'b011)[*2] |-> use_internal_osc_out;
   endproperty
   a_osc_mode: assert property (p_osc_mode) else $error("oscillator not used in mode 011");
   property p_osc_noext;
      !ext_clock_detect_in[*5] |-> use_internal_osc_out;
   endproperty
   a_osc_noext: assert property (p_osc_noext) else $error("oscillator unused without clock");
   property p_osc_ext;
      (ext_clock_detect_in && active_mode_out != 3'b011)[*5] |-> !use_internal_osc_out;
   endproperty
   a_osc_ext: assert property (p_osc_ext) else $error("oscillator used with external clock");
   property p_done_late;
      $rose(mode_done_out) |-> $past(powerdown_n_pin_in, 20);
   endproperty
   a_done_late: assert property (p_done_late) else $error("mode done rose too early");
   property p_done_low;
      !powerdown_n_pin_in[*5] |-> !mode_done_out;
   endproperty
   a_done_low: assert property (p_done_low) else $error("mode done high in power-down");
   property p_pd_regs;
      !powerdown_n_pin_in[*5] |-> refin_divider_out == 3'h0 && !internal_osc_range_select_out;
   endproperty
   a_pd_regs: assert property (p_pd_regs) else $error("clock control not reset");
   property p_quiet;
      (powerdown_n_pin_in && scl_in && sda_in && !$rose(rx_lock_in))[*8] |-> $stable(cfg);
   endproperty
   a_quiet: assert property (p_quiet) else $error("configuration changed on idle bus");
   property p_oe_low;
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("data line changed with SCL high");
   c_done: cover property ($rose(mode_done_out));
   c_lock: cover property ($rose(rx_lock_in) ##2 raw10_legacy_select_out);
   c_osc: cover property ($rose(use_internal_osc_out));
endmodule // smcc_checker

bind smcc_mode_clock_config smcc_checker chk_u (.*);

// [verif/smcc_deser_model.sv]
// Purpose: Remote deserializer side of the control channel.
// Assumes: Lock and format share the block clock.
// Notes: Each lock drops first so a fresh rise is seen.
module smcc_deser_model
(
   input wire logic clock_in,
   output logic rx_lock_out,
   output logic [1:0] legacy_format_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      rx_lock_out = 1'b0;
      legacy_format_out = 2'b00;
   end
   task automatic lock_link(input logic [1:0] fmt);
      @(posedge clock_in);
      rx_lock_out <= 1'b0;
      legacy_format_out <= fmt;
      repeat (4) @(posedge clock_in);
      rx_lock_out <= 1'b1;
      repeat (4) @(posedge clock_in);
   endtask
endmodule // smcc_deser_model

// [verif/serializer_mode_clock_config_bench.sv]
// Purpose: Self-checking bench for the mode and clock configuration block.
// Assumes: I2C phases of eight cycles, the minimum the checker assumes.
// Notes: Registers are checked by I2C reads and on the decoded outputs.
module serializer_mode_clock_config_bench;
   import smcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ID = 7'h5A; // Arbitrary strapped address.
   logic clock = 1'b0, reset = 1'b1, pdb_n = 1'b0, ext_clk = 1'b1, scl = 1'b1, sda_m = 1'b1;
   logic [2:0] strap = 3'b010;
   logic [2:0] modes [4] = '{3'b000, 3'b010, 3'b011, 3'b101};
   logic rx_lock, sda_oe, done, raw10, raw12, osc, use_osc;
   logic [1:0] fmt;
   logic [2:0] mode, div;
   int errors = 0, n_compared = 0, cycles = 0;
   wire sda = sda_m & ~sda_oe;
   smcc_mode_clock_config dut_u (.clock_in(clock), .reset_in(reset), .powerdown_n_pin_in(pdb_n),
      .strap_mode_in(strap), .strap_id_in(ID), .ext_clock_detect_in(ext_clk),
      .rx_lock_in(rx_lock), .legacy_format_in(fmt), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe_out(sda_oe), .active_mode_out(mode), .mode_done_out(done),
      .raw10_legacy_select_out(raw10), .raw12_legacy_select_out(raw12),
      .refin_divider_out(div), .internal_osc_range_select_out(osc), .use_internal_osc_out(use_osc));
   smcc_deser_model partner_u (.clock_in(clock), .rx_lock_out(rx_lock), .legacy_format_out(fmt));
   initial
   begin
      forever #25 clock = ~clock;
   end
   task automatic results;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic phase(input logic s, input logic d);
      scl <= s;
      sda_m <= d;
      repeat (8) @(posedge clock);
   endtask
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         phase(1'b0, b[i]);
         phase(1'b1, b[i]);
      end
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      check("ack", {7'h00, sda}, 8'h00);
   endtask
   task automatic head(input logic [7:0] a);
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      phase(1'b1, 1'b0);
      put_byte(a);
   endtask
   task automatic stop;
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b0);
      phase(1'b1, 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      head({ID, 1'b0});
      put_byte(a);
      put_byte(v);
      stop();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      head({ID, 1'b0});
      put_byte(a);
      head({ID, 1'b1});
      for (int i = 7; i >= 0; i--)
      begin
         phase(1'b0, 1'b1);
         phase(1'b1, 1'b1);
         v[i] = sda;
      end
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      stop();
      check("register", v, exp);
   endtask
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         errors++;
         results();
      end
   end
   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      pdb_n <= 1'b1;
      repeat (30) @(posedge clock);
      check("mode_done", {7'h00, done}, 8'h01);
      rd(ADDR_FORWARD_MODE, 8'h0A);
      rd(ADDR_PLL_REFERENCE, 8'h03);
      rd(8'h20, 8'h00);
      wr(ADDR_FORWARD_MODE, 8'h05);
      rd(ADDR_FORWARD_MODE, 8'h0A);
      $display("test strap mode done");
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_FORWARD_MODE, {5'h02, modes[i]});
         rd(ADDR_FORWARD_MODE, {5'h03, modes[i]});
         check("mode", {5'h00, mode}, {5'h00, modes[i]});
         check("use_osc", {7'h00, use_osc}, {7'h00, modes[i] == 3'b011});
      end
      wr(ADDR_FORWARD_MODE, 8'h00);
      check("mode", {5'h00, mode}, 8'h02);
      $display("test override done");
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_PLL_REFERENCE, {1'b0, 3'(i), i[0], 3'b011});
         check("div", {5'h00, div}, 8'(i));
         check("osc", {7'h00, osc}, {7'h00, i[0]});
      end
      $display("test clock control done");
      partner_u.lock_link(2'b11);
      rd(ADDR_LEGACY_FORMAT, 8'h06);
      wr(ADDR_LEGACY_FORMAT, 8'h03);
      partner_u.lock_link(2'b10);
      rd(ADDR_LEGACY_FORMAT, 8'h03);
      check("raw", {6'h00, raw10, raw12}, 8'h01);
      $display("test autoload done");
      ext_clk <= 1'b0;
      repeat (6) @(posedge clock);
      check("use_osc", {7'h00, use_osc}, 8'h01);
      strap <= 3'b011;
      pdb_n <= 1'b0;
      repeat (10) @(posedge clock);
      check("mode_done", {7'h00, done}, 8'h00);
      pdb_n <= 1'b1;
      repeat (30) @(posedge clock);
      check("mode", {5'h00, mode}, 8'h03);
      rd(ADDR_PLL_REFERENCE, 8'h03);
      rd(ADDR_FORWARD_MODE, 8'h0B);
      $display("test power-down done");
      results();
   end
endmodule // serializer_mode_clock_config_bench
